/* hdl/ir_secondary_startup.sv */
// start-up sequencing, bit tick and host modem-control handling
`timescale 1ns/10ps
// Functional notes
// - both ports run at a fixed 9600 baud from the device clock with no rate choice.
// - after power-up the power-up timer runs, then the oscillator start-up timer, before tick and handshake work; the carrier bit is always forwarded.
// - the device stays in reset while the reset input is low.
// - on reset release an internal reset sequence runs and only then does normal operation start.
// - ready-to-receive is a local handshake and never goes into the remote flow-control bits.
// - the sampled carrier-detect input is sent to the primary as its carrier bit, 1 no carrier, 0 carrier.
// - all internal timing, including the bit clock, comes from the single device clock.
// - the bit clock gives sixteen ticks per bit, timing the start bit and eight data bits.
// - after a received packet the host must lower ready-to-receive or the delivery must complete, else the link times out and drops.
module ir_secondary_startup #(
	parameter int unsigned POWERUP_CYCLES   = ir_startup_pkg::POWERUP_CYCLES,
	parameter int unsigned OSC_START_CYCLES = ir_startup_pkg::OSC_START_CYCLES,
	parameter int unsigned LINK_TMO_CYCLES = ir_startup_pkg::LINK_TMO_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic host_rx_ready_n_i,
	input  wire logic carrier_present_n_i,
	input  wire logic packet_rcvd_i,
	input  wire logic deliver_done_i,
	output logic      operational_o,
	output logic      sixteenth_bit_tick_o,
	output logic      host_deliver_ok_o,
	output logic      link_carrier_bit_o,
	output logic      link_timeout_o
);
	typedef enum logic [2:0] {
		ST_POWERUP,
		ST_OSC_START,
		ST_RSTSEQ,
		ST_RUN
	} phase_t;

	phase_t      phase_q;
	logic [31:0] cnt_q;
	logic [3:0]  seq_q;
	logic [7:0]  div_q;
	logic        host_rdy_n;
	logic        carrier_n;
	logic        pending_q;
	logic [31:0] tmo_q;

	function automatic logic reached(input logic [31:0] c, input int unsigned lim);
		reached = (c >= 32'(lim - 1));
	endfunction : reached

	////////////////////////////////////////////////////////////////////////////////
	// input synchronisers
	ir_in_sync u_ready_sync (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.pin_i   (host_rx_ready_n_i),
		.level_o (host_rdy_n)
	);
	ir_in_sync u_carrier_sync (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.pin_i   (carrier_present_n_i),
		.level_o (carrier_n)
	);

	////////////////////////////////////////////////////////////////////////////////
	// start-up phases; reset low parks the machine at the power-up timer start
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			phase_q <= ST_POWERUP;
			cnt_q   <= 32'h0;
			seq_q   <= 4'h0;
		end else begin
			case (phase_q)
				ST_POWERUP: begin
					if (reached(cnt_q, POWERUP_CYCLES)) begin
						phase_q <= ST_OSC_START;
						cnt_q   <= 32'h0;
					end else begin
						cnt_q <= cnt_q + 32'h1;
					end
				end
				ST_OSC_START: begin
					if (reached(cnt_q, OSC_START_CYCLES)) begin
						phase_q <= ST_RSTSEQ;
						cnt_q   <= 32'h0;
					end else begin
						cnt_q <= cnt_q + 32'h1;
					end
				end
				ST_RSTSEQ: begin
					if (seq_q == ir_startup_pkg::RST_SEQ_CYCLES - 4'h1) begin
						phase_q <= ST_RUN;
					end else begin
						seq_q <= seq_q + 4'h1;
					end
				end
				ST_RUN: begin
					phase_q <= ST_RUN;
				end
				default: begin
					phase_q <= ST_POWERUP;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			operational_o <= 1'b0;
		end else begin
			operational_o <= (phase_q == ST_RUN);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bit tick: fixed divider, no rate select
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_q                <= 8'h0;
			sixteenth_bit_tick_o <= 1'b0;
		end else if (phase_q != ST_RUN) begin
			div_q                <= 8'h0;
			sixteenth_bit_tick_o <= 1'b0;
		end else if (div_q == ir_startup_pkg::TICK_DIV_M1) begin
			div_q                <= 8'h0;
			sixteenth_bit_tick_o <= 1'b1;
		end else begin
			div_q                <= div_q + 8'h1;
			sixteenth_bit_tick_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// carrier bit and local handshake; ready never reaches the link bits
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			link_carrier_bit_o <= 1'b1;
			host_deliver_ok_o  <= 1'b0;
		end else begin
			link_carrier_bit_o <= carrier_n;
			host_deliver_ok_o  <= operational_o && !host_rdy_n;
		end
	end

	// packet waits for host ready; new packet wins over delivery clear
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pending_q      <= 1'b0;
			tmo_q          <= 32'h0;
			link_timeout_o <= 1'b0;
		end else begin
			link_timeout_o <= 1'b0;
			if (!operational_o) begin
				pending_q <= 1'b0;
				tmo_q     <= 32'h0;
			end else if (packet_rcvd_i) begin
				pending_q <= 1'b1;
				tmo_q     <= 32'h0;
			end else if (pending_q && (deliver_done_i || !host_rdy_n)) begin
				pending_q <= !deliver_done_i;
				tmo_q     <= 32'h0;
			end else if (pending_q && reached(tmo_q, LINK_TMO_CYCLES)) begin
				pending_q      <= 1'b0;
				tmo_q          <= 32'h0;
				link_timeout_o <= 1'b1;
			end else if (pending_q) begin
				tmo_q <= tmo_q + 32'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	int unsigned tick_gap_q;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tick_gap_q <= 0;
		end else if (sixteenth_bit_tick_o) begin
			tick_gap_q <= 1;
		end else if (tick_gap_q != 0) begin
			tick_gap_q <= tick_gap_q + 1;
		end
	end

	tick_period_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		sixteenth_bit_tick_o && tick_gap_q != 0 |-> tick_gap_q == ir_startup_pkg::TICK_DIV)
		else $error("bit tick period wrong");
	tick_gated_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		sixteenth_bit_tick_o |-> $past(phase_q == ST_RUN))
		else $error("tick before start-up done");
	osc_after_power_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		phase_q == ST_OSC_START && $past(phase_q) != ST_OSC_START |-> $past(phase_q) == ST_POWERUP)
		else $error("oscillator timer without power-up timer");
	seq_before_run_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		phase_q == ST_RUN && $past(phase_q) != ST_RUN |-> $past(phase_q) == ST_RSTSEQ
		&& $past(seq_q) == ir_startup_pkg::RST_SEQ_CYCLES - 4'h1)
		else $error("run before reset sequence end");
	oper_follows_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(phase_q == ST_RUN) |=> operational_o)
		else $error("operational late");
	carrier_map_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$changed(carrier_n) |=> link_carrier_bit_o == $past(carrier_n))
		else $error("carrier bit not forwarded");
	deliver_ok_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		host_deliver_ok_o |-> $past(!host_rdy_n) && $past(operational_o))
		else $error("delivery without host ready");
	tmo_only_pending_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		link_timeout_o |-> $past(pending_q) && $past(host_rdy_n) && !pending_q)
		else $error("timeout without waiting packet");
	ready_clears_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		pending_q && !host_rdy_n && !packet_rcvd_i |=> !link_timeout_o && tmo_q == 0)
		else $error("host ready did not stop timeout");
	// a clear in the packet's own cycle must not drop the fresh packet
	packet_wins_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		operational_o && packet_rcvd_i |=> pending_q && tmo_q == 0)
		else $error("new packet lost to delivery clear");

	run_c: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(operational_o));
	timeout_c: cover property (@(posedge clk_i) disable iff (!rst_b_i) link_timeout_o);
	deliver_c: cover property (@(posedge clk_i) disable iff (!rst_b_i) pending_q ##1 host_deliver_ok_o);
	carrier_c: cover property (@(posedge clk_i) disable iff (!rst_b_i) $fell(link_carrier_bit_o));
endmodule : ir_secondary_startup

/* hdl/ir_startup_pkg.sv */
// constants for the infrared secondary start-up and host handshake block
package ir_startup_pkg;
	// device clock rate feeding clk_i (10 MHz here)
	localparam int unsigned CLK_HZ             = 10_000_000;
	localparam int unsigned BAUD               = 9600;
	localparam int unsigned TICKS_PER_BIT      = 16;
	// divider to one sixteenth-bit tick, rounded down
	localparam int unsigned TICK_DIV           = CLK_HZ / (BAUD * TICKS_PER_BIT);
	localparam logic [7:0]  TICK_DIV_M1        = 8'(TICK_DIV - 1);
	// start-up delays in microseconds; plain defaults
	localparam int unsigned POWERUP_US         = 72_000;
	localparam int unsigned OSC_START_US       = 103;
	localparam int unsigned POWERUP_CYCLES     = (POWERUP_US * 10) * (CLK_HZ / 10_000_000);
	localparam int unsigned OSC_START_CYCLES   = (OSC_START_US * 10) * (CLK_HZ / 10_000_000);
	// internal reset sequence length in cycles
	localparam logic [3:0]  RST_SEQ_CYCLES     = 4'h8;
	// link timeout waiting for host ready, in microseconds
	localparam int unsigned LINK_TMO_US        = 3_000_000;
	localparam int unsigned LINK_TMO_CYCLES    = LINK_TMO_US * (CLK_HZ / 1_000_000);
	localparam logic [2:0]  SYNC_RESET         = 3'h7;
endpackage : ir_startup_pkg

/* hdl/ir_in_sync.sv */
// three-stage synchroniser with agreement check for one pin input
`timescale 1ns/10ps
module ir_in_sync (
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic pin_i,
	output logic      level_o
);
	logic [2:0] sync_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync_q <= ir_startup_pkg::SYNC_RESET;
		end else begin
			sync_q <= {sync_q[1:0], pin_i};
		end
	end

	// stage 0 only feeds stage 1; change is taken when stages 1 and 2 agree
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			level_o <= 1'b1;
		end else if (sync_q[1] == sync_q[2]) begin
			level_o <= sync_q[2];
		end
	end
endmodule : ir_in_sync

/* sim/host_ctrl_model.sv */
// host controller model driving ready-to-receive and carrier-detect pins
`timescale 1ns/10ps
module host_ctrl_model (
	input  wire logic clk_i,
	input  wire logic operational_i,
	input  wire logic want_ready_i,
	input  wire logic carrier_on_i,
	output logic      host_rx_ready_n_o,
	output logic      carrier_present_n_o
);
	initial begin
		host_rx_ready_n_o   = 1'b1;
		carrier_present_n_o = 1'b1;
	end
	// no readiness shown before the device is up
	always @(posedge clk_i) begin
		host_rx_ready_n_o   <= ~(want_ready_i & operational_i);
		carrier_present_n_o <= ~carrier_on_i;
	end
endmodule : host_ctrl_model

/* sim/ir_secondary_startup_tb.sv */
// testbench for start-up sequencing, bit tick and host handshake
`timescale 1ns/10ps
module ir_secondary_startup_tb;
	localparam int unsigned T_POWERUP = 20;
	localparam int unsigned T_OSC     = 10;
	localparam int unsigned TMO  = 200;
	logic clk_i, rst_b_i, rdy_n, car_n, packet_rcvd_i, deliver_done_i;
	logic op, tick, dok, carb, tmo, want_ready, carrier_on;
	int   fails, checks, n;
	ir_secondary_startup #(
		.POWERUP_CYCLES(T_POWERUP), .OSC_START_CYCLES(T_OSC), .LINK_TMO_CYCLES(TMO)
	) ir_secondary_startup_i (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .host_rx_ready_n_i(rdy_n), .carrier_present_n_i(car_n),
		.packet_rcvd_i(packet_rcvd_i), .deliver_done_i(deliver_done_i), .operational_o(op),
		.sixteenth_bit_tick_o(tick), .host_deliver_ok_o(dok), .link_carrier_bit_o(carb), .link_timeout_o(tmo));
	host_ctrl_model host_ctrl_model_i (.clk_i(clk_i), .operational_i(op), .want_ready_i(want_ready),
		.carrier_on_i(carrier_on), .host_rx_ready_n_o(rdy_n), .carrier_present_n_o(car_n));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_i);
	endtask : cyc
	task automatic chk(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic summarize;
		$display("mismatches %0d comparisons %0d", fails, checks);
		if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize
	task automatic pulse_packet;
		packet_rcvd_i <= 1'b1;
		cyc(1);
		packet_rcvd_i <= 1'b0;
	endtask : pulse_packet
	////////////////////////////////////////////////////////////////////////////////
	// reset values, then count release-to-operational
	task automatic t_reset;
		rst_b_i <= 1'b0;
		cyc(1);
		#1;
		chk(op, 1'b0);
		chk(carb, 1'b1);
		chk(dok | tmo | tick, 1'b0);
		@(posedge clk_i) rst_b_i <= 1'b1;
		n = 0;
		while (op !== 1'b1 && n < 200) begin
			cyc(1);
			n++;
		end
		chk(n >= T_POWERUP + T_OSC + 8 && n <= T_POWERUP + T_OSC + 11, 1'b1);
	endtask : t_reset
	task automatic t_tick;
		n = 0;
		while (tick !== 1'b1 && n < 100) begin cyc(1); n++; end
		n = 0;
		do begin cyc(1); n++; end while (tick !== 1'b1 && n < 100);
		chk(n == ir_startup_pkg::TICK_DIV, 1'b1);
	endtask : t_tick
	// sync path is 4-5 cycles; 8 leaves margin
	task automatic t_pins;
		carrier_on <= 1'b1;
		want_ready <= 1'b1;
		cyc(8);
		chk(carb, 1'b0);
		chk(dok, 1'b1);
		carrier_on <= 1'b0;
		want_ready <= 1'b0;
		cyc(8);
		chk(carb, 1'b1);
		chk(dok, 1'b0);
	endtask : t_pins
	// with_done puts a delivery clear in the packet's own cycle; the packet must win
	task automatic t_timeout(input logic with_done);
		deliver_done_i <= with_done;
		pulse_packet();
		deliver_done_i <= 1'b0;
		n = 1;
		while (tmo !== 1'b1 && n < 400) begin cyc(1); n++; end
		chk(n >= TMO - 2 && n <= TMO + 3, 1'b1);
		cyc(1);
		chk(tmo, 1'b0);
	endtask : t_timeout
	// delivery done, or host ready, must prevent the timeout
	task automatic t_no_timeout(input logic by_ready);
		int seen;
		seen = 0;
		pulse_packet();
		if (by_ready) want_ready <= 1'b1;
		else deliver_done_i <= 1'b1;
		cyc(1);
		deliver_done_i <= 1'b0;
		repeat (TMO + 40) begin cyc(1); if (tmo === 1'b1) seen++; end
		chk(seen == 0, 1'b1);
		want_ready <= 1'b0;
		cyc(8);
	endtask : t_no_timeout
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		fails = 0;
		checks = 0;
		rst_b_i = 1'b0;
		packet_rcvd_i = 1'b0;
		deliver_done_i = 1'b0;
		want_ready = 1'b0;
		carrier_on = 1'b0;
		t_reset();
		t_tick();
		t_pins();
		t_timeout(1'b0);
		t_no_timeout(1'b0);
		t_no_timeout(1'b1);
		t_reset();
		t_timeout(1'b1);
		summarize();
	end
	initial begin
		#(100 * 20000);
		fails++;
		summarize();
	end
endmodule : ir_secondary_startup_tb
